// ### rtl/pec_regs.sv
// Event flags, interrupt pin and cable diagnostic registers behind a serial management slave
// Behaviour
// - Bit 10 enables link-down interrupt, resets 0
// - Bit 9 enables remote-fault interrupt, resets 0
// - Bit 8 enables link-up interrupt, resets 0
// - Bit 7 flags jabber, clears on read
// - Bit 6 flags receive error, clears on read
// - Bit 5 flags page received, clears on read
// - Bit 4 flags parallel-detect fault, clears on read
// - Bit 3 flags partner acknowledge, clears on read
// - Bit 2 flags link down, clears on read
// - Bit 1 flags remote fault, clears on read
// - Bit 0 flags link up, clears on read
// - Writing start bit runs test; self-clears
// - Start bit low means results valid
// - Two-bit result: normal, open, short, failed
// - Short-cable bit set below ten metres
// - Control bit 9 reports flow-control capability
// - Upper bits enable remaining five interrupts
// - Polarity bit selects active-high or active-low pin
`timescale 1ns/10ps
`default_nettype none

module pec_regs
  import pec_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       nrst_in,
  input  wire logic [4:0] phy_addr_in,
  input  wire logic       mdc_in,
  input  wire logic       mdio_in,
  output logic            mdio_out,
  output logic            mdio_oe_n_out,
  input  wire logic [7:0] evt_in,
  output logic            irq_out,
  input  wire logic       flow_ctrl_cap_in,
  output logic            diag_start_out,
  output logic            diag_busy_out,
  input  wire logic       diag_done_in,
  input  wire logic [1:0] diag_result_in,
  input  wire logic       diag_short_in,
  input  wire logic [8:0] diag_count_in
);

  pec_state_t  state_q;
  logic        mdc_q;
  logic [5:0]  pre_cnt_q;
  logic [4:0]  cnt_q;
  logic [11:0] hdr_q;
  logic [15:0] sh_q;
  logic        is_rd_q;
  logic [4:0]  reg_q;
  logic        mdio_q;
  logic        oe_n_q;
  logic [7:0]  en_q;
  logic [7:0]  flags_q;
  logic        irq_q;
  logic        pol_q;
  logic        pause_q;
  logic        run_q;
  logic        start_q;
  logic [1:0]  res_q;
  logic        short_q;
  logic [2:0]  rsvd_q;
  logic [8:0]  fcnt_q;
  logic        mdc_rise;
  logic [12:0] frame;
  logic        hdr_done;
  logic        hdr_ok;
  logic        rd_take;
  logic        rd_clr;
  logic        wr_go;
  logic [15:0] wr_data;
  logic        any_evt;
  logic        diag_fin;
  logic        diag_go;

  function automatic logic [15:0] rd_word(input logic [4:0] addr);
    logic [15:0] w;
    w = WORD_ZERO;
    case (addr)
      REG_EVT_IRQ:  w = {en_q, flags_q};
      REG_CABLE:    w = {run_q, res_q, short_q, rsvd_q, fcnt_q};
      REG_CTRL_ONE: w[PAUSE_BIT] = pause_q;
      REG_CTRL_TWO: w[IRQ_POL_BIT] = pol_q;
      default:      w = WORD_ZERO;
    endcase
    return w;
  endfunction

  assign mdc_rise = mdc_in & ~mdc_q;
  assign frame    = {hdr_q, mdio_in};
  assign hdr_done = (state_q == ST_HDR) && mdc_rise && (cnt_q == HDR_LAST);
  assign hdr_ok   = hdr_done && frame[12] && (frame[9:5] == phy_addr_in);
  assign rd_take  = hdr_ok && (frame[11:10] == OP_READ);
  // Read of the event register clears its flags in the capture cycle
  assign rd_clr   = rd_take && (frame[4:0] == REG_EVT_IRQ);
  assign wr_go    = (state_q == ST_WR) && mdc_rise && (cnt_q == DATA_LAST);
  assign wr_data  = {sh_q[14:0], mdio_in};
  assign any_evt  = |(flags_q & en_q);
  assign diag_fin = run_q && diag_done_in;
  assign diag_go  = wr_go && (reg_q == REG_CABLE) && wr_data[CBL_START_BIT] && !run_q;

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      mdc_q <= 1'b1;
    else
      mdc_q <= mdc_in;
  end

  // Management frame engine
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      state_q   <= ST_PRE;
      pre_cnt_q <= 6'd0;
      cnt_q     <= 5'd0;
      hdr_q     <= 12'h000;
      sh_q      <= WORD_ZERO;
      is_rd_q   <= 1'b0;
      reg_q     <= 5'h00;
      mdio_q    <= 1'b1;
      oe_n_q    <= 1'b1;
    end
    else if (mdc_rise)
    begin
      case (state_q)
        ST_PRE:
        begin
          if (mdio_in)
          begin
            if (pre_cnt_q != PRE_LEN)
              pre_cnt_q <= pre_cnt_q + 6'd1;
          end
          else if (pre_cnt_q == PRE_LEN)
          begin
            state_q <= ST_HDR;
            cnt_q   <= 5'd0;
          end
          else
            pre_cnt_q <= 6'd0;
        end
        ST_HDR:
        begin
          hdr_q <= frame[11:0];
          cnt_q <= cnt_q + 5'd1;
          if (hdr_done)
          begin
            cnt_q     <= 5'd0;
            pre_cnt_q <= 6'd0;
            reg_q     <= frame[4:0];
            is_rd_q   <= rd_take;
            if (rd_take)
            begin
              state_q <= ST_TA;
              sh_q    <= rd_word(frame[4:0]);
            end
            else if (hdr_ok && (frame[11:10] == OP_WRITE))
              state_q <= ST_TA;
            else
              state_q <= ST_PRE;
          end
        end
        ST_TA:
        begin
          if (cnt_q == 5'd0)
          begin
            cnt_q <= 5'd1;
            if (is_rd_q)
            begin
              mdio_q <= 1'b0;
              oe_n_q <= 1'b0;
            end
          end
          else
          begin
            cnt_q <= 5'd0;
            if (is_rd_q)
            begin
              state_q <= ST_RD;
              mdio_q  <= sh_q[15];
              sh_q    <= {sh_q[14:0], 1'b0};
            end
            else
              state_q <= ST_WR;
          end
        end
        ST_RD:
        begin
          if (cnt_q == DATA_LAST)
          begin
            state_q <= ST_PRE;
            mdio_q  <= 1'b1;
            oe_n_q  <= 1'b1;
          end
          else
          begin
            mdio_q <= sh_q[15];
            sh_q   <= {sh_q[14:0], 1'b0};
            cnt_q  <= cnt_q + 5'd1;
          end
        end
        ST_WR:
        begin
          sh_q  <= wr_data;
          cnt_q <= cnt_q + 5'd1;
          if (wr_go)
            state_q <= ST_PRE;
        end
        default:
        begin
          state_q <= ST_PRE;
          oe_n_q  <= 1'b1;
        end
      endcase
    end
  end

  // Interrupt enables and pin polarity
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      en_q  <= EVT_EN_RST;
      pol_q <= 1'b0;
    end
    else if (wr_go)
    begin
      if (reg_q == REG_EVT_IRQ)
        en_q <= wr_data[15:EVT_EN_LSB];
      if (reg_q == REG_CTRL_TWO)
        pol_q <= wr_data[IRQ_POL_BIT];
    end
  end

  // Sticky event flags, one per event source
  genvar gi;
  generate
    for (gi = 0; gi < EVT_NUM; gi++)
    begin : g_flag
      always_ff @(posedge clk_in or negedge nrst_in)
      begin
        if (!nrst_in)
          flags_q[gi] <= EVT_FLAG_RST[gi];
        else
          flags_q[gi] <= evt_in[gi] | (flags_q[gi] & ~rd_clr);
      end
      property p_flag_set;
        @(posedge clk_in) disable iff (!nrst_in)
        evt_in[gi] |=> flags_q[gi];
      endproperty
      a_flag_set: assert property (p_flag_set) else $error("event flag not set");
      property p_flag_clear;
        @(posedge clk_in) disable iff (!nrst_in)
        rd_clr && !evt_in[gi] |=> !flags_q[gi];
      endproperty
      a_flag_clear: assert property (p_flag_clear) else $error("event flag not cleared by read");
      property p_flag_hold;
        @(posedge clk_in) disable iff (!nrst_in)
        flags_q[gi] && !rd_clr |=> flags_q[gi] [*1];
      endproperty
      a_flag_hold: assert property (p_flag_hold) else $error("event flag dropped");
    end
  endgenerate

  // Interrupt pin, polarity applied
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      irq_q <= 1'b1;
    else
      irq_q <= pol_q ? any_evt : ~any_evt;
  end

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      pause_q <= 1'b0;
    else
      pause_q <= flow_ctrl_cap_in;
  end

  // Cable test sequencing and result capture
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      run_q   <= 1'b0;
      start_q <= 1'b0;
      res_q   <= CBL_RES_RST;
      short_q <= 1'b0;
      fcnt_q  <= CBL_CNT_RST;
    end
    else
    begin
      start_q <= diag_go;
      if (diag_fin)
      begin
        run_q   <= 1'b0;
        res_q   <= diag_result_in;
        short_q <= diag_short_in;
        fcnt_q  <= diag_count_in;
      end
      else if (diag_go)
        run_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      rsvd_q <= CBL_RSVD_RST;
    else if (wr_go && (reg_q == REG_CABLE))
      rsvd_q <= wr_data[11:CBL_RSVD_LSB];
  end

  assign mdio_out       = mdio_q;
  assign mdio_oe_n_out  = oe_n_q;
  assign irq_out        = irq_q;
  assign diag_start_out = start_q;
  assign diag_busy_out  = run_q;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);
  property p_en_hold;
    !(wr_go && (reg_q == REG_EVT_IRQ)) |=> $stable(en_q);
  endproperty
  a_en_hold: assert property (p_en_hold) else $error("enable bits changed without a write");
  property p_en_write;
    wr_go && (reg_q == REG_EVT_IRQ) |=> en_q == $past(wr_data[15:8]);
  endproperty
  a_en_write: assert property (p_en_write) else $error("enable bits not written");
  property p_irq_high;
    (any_evt && pol_q) [*2] |-> irq_out;
  endproperty
  a_irq_high: assert property (p_irq_high) else $error("active-high interrupt not asserted");
  property p_irq_low;
    (any_evt && !pol_q) [*2] |-> !irq_out;
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("active-low interrupt not asserted");
  property p_irq_idle;
    (!any_evt && !pol_q) [*2] |-> irq_out;
  endproperty
  a_irq_idle: assert property (p_irq_idle) else $error("interrupt pin not idle");
  property p_diag_done;
    diag_fin |=> !diag_busy_out && !diag_start_out;
  endproperty
  a_diag_done: assert property (p_diag_done) else $error("test bit did not self-clear");
  property p_diag_start;
    diag_go |=> diag_start_out && diag_busy_out ##1 !diag_start_out;
  endproperty
  a_diag_start: assert property (p_diag_start) else $error("test start not taken");
  property p_diag_capture;
    diag_fin |=> res_q == $past(diag_result_in) && short_q == $past(diag_short_in)
                 && fcnt_q == $past(diag_count_in);
  endproperty
  a_diag_capture: assert property (p_diag_capture) else $error("results not valid at completion");
  property p_diag_stable;
    !diag_fin |=> $stable(res_q) && $stable(short_q) && $stable(fcnt_q);
  endproperty
  a_diag_stable: assert property (p_diag_stable) else $error("results changed outside completion");
  property p_pause_read;
    rd_take && (frame[4:0] == REG_CTRL_ONE) |=> sh_q[PAUSE_BIT] == $past(pause_q) && sh_q[15:10] == 6'h00;
  endproperty
  a_pause_read: assert property (p_pause_read) else $error("capability bit misread");
endmodule

`default_nettype wire

// ### rtl/pec_pkg.sv
// Constants for the event, interrupt and cable diagnostic register logic
package pec_pkg;

  // Register numbers on the management interface
  localparam logic [4:0]  REG_EVT_IRQ   = 5'h1B;
  localparam logic [4:0]  REG_CABLE     = 5'h1D;
  localparam logic [4:0]  REG_CTRL_ONE  = 5'h1E;
  localparam logic [4:0]  REG_CTRL_TWO  = 5'h1F;

  // Field positions
  localparam int          EVT_EN_LSB    = 8;
  localparam int          EVT_NUM       = 8;
  localparam int          CBL_START_BIT = 15;
  localparam int          CBL_RES_LSB   = 13;
  localparam int          CBL_SHORT_BIT = 12;
  localparam int          CBL_RSVD_LSB  = 9;
  localparam int          PAUSE_BIT     = 9;
  localparam int          IRQ_POL_BIT   = 9;

  // Values after reset
  localparam logic [7:0]  EVT_EN_RST    = 8'h00;
  localparam logic [7:0]  EVT_FLAG_RST  = 8'h00;
  localparam logic [1:0]  CBL_RES_RST   = 2'h0;
  localparam logic [2:0]  CBL_RSVD_RST  = 3'h0;
  localparam logic [8:0]  CBL_CNT_RST   = 9'h000;
  localparam logic [15:0] WORD_ZERO     = 16'h0000;

  // Management frame layout
  localparam logic [5:0]  PRE_LEN       = 6'd32;
  localparam logic [4:0]  HDR_LAST      = 5'd12;
  localparam logic [4:0]  DATA_LAST     = 5'd15;
  localparam logic [1:0]  OP_READ       = 2'b10;
  localparam logic [1:0]  OP_WRITE      = 2'b01;

  typedef enum logic [4:0]
  {
    ST_PRE  = 5'b00001,
    ST_HDR  = 5'b00010,
    ST_TA   = 5'b00100,
    ST_RD   = 5'b01000,
    ST_WR   = 5'b10000
  } pec_state_t;

endpackage

// ### bench/pec_host.sv
// Management host model: clocks frames out and reads data back
`timescale 1ns/10ps
`default_nettype none

module pec_host
  import pec_pkg::*;
(
  input  wire logic clk_in,
  output logic      mdc_out,
  output logic      mdio_line_out,
  input  wire logic mdio_dev_in,
  input  wire logic mdio_oe_n_in
);
  logic hb  = 1'b1;
  logic drv = 1'b0;

  // Wire level, pulled up when nobody drives
  assign mdio_line_out = !mdio_oe_n_in ? mdio_dev_in : (drv ? hb : 1'b1);

  initial mdc_out = 1'b1;

  // One bit: two clocks low, two high; sample just before the rise
  task automatic cyc(input logic b, input logic d, output logic s);
    @(posedge clk_in) #10;
    mdc_out = 1'b0;
    hb = b;
    drv = d;
    repeat (2) @(posedge clk_in);
    #10;
    s = mdio_line_out;
    mdc_out = 1'b1;
    @(posedge clk_in);
  endtask

  task automatic xfer(input logic rd, input logic [4:0] pa, input logic [4:0] ra,
                      input logic [15:0] wd, output logic [15:0] q);
    logic [31:0] f;
    logic        s;
    f = {2'b01, rd ? OP_READ : OP_WRITE, pa, ra, rd ? 2'b11 : 2'b10, wd};
    for (int i = 0; i < 32; i++)
      cyc(1'b1, 1'b1, s);
    // Released during turnaround and data of a read
    for (int i = 31; i >= 0; i--)
    begin
      cyc(f[i], !rd || i > 17, s);
      if (i < 16)
        q[i] = s;
    end
    #10;
    drv = 1'b0;
  endtask
endmodule

`default_nettype wire

// ### bench/pec_regs_tb.sv
// Self-checking bench for the event, interrupt and cable diagnostic registers
`timescale 1ns/10ps
`default_nettype none

module pec_regs_tb
  import pec_pkg::*;
();
  localparam logic [4:0] PA = 5'h05;
  logic       clk_in    = 1'b0;
  logic       nrst_in   = 1'b0;
  logic       mdc, line, dev, oe_n, irq, start, busy;
  logic       done      = 1'b0;
  logic       short     = 1'b0;
  logic       cap       = 1'b0;
  logic [7:0] evt       = 8'h00;
  logic [1:0] res       = 2'h0;
  logic [8:0] cnt       = 9'h000;
  int         bad_count = 0;
  int         checks    = 0;
  int         starts    = 0;

  always #50 clk_in = ~clk_in;

  always @(posedge clk_in)
    if (start)
      starts <= starts + 1;

  pec_regs u_pec_regs (.clk_in(clk_in), .nrst_in(nrst_in), .phy_addr_in(PA), .mdc_in(mdc),
    .mdio_in(line), .mdio_out(dev), .mdio_oe_n_out(oe_n), .evt_in(evt), .irq_out(irq),
    .flow_ctrl_cap_in(cap), .diag_start_out(start), .diag_busy_out(busy), .diag_done_in(done),
    .diag_result_in(res), .diag_short_in(short), .diag_count_in(cnt));

  pec_host u_pec_host (.clk_in(clk_in), .mdc_out(mdc), .mdio_line_out(line),
    .mdio_dev_in(dev), .mdio_oe_n_in(oe_n));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #10;
  endtask

  task automatic rdc(input logic [4:0] ra, input logic [15:0] e);
    logic [15:0] v;
    u_pec_host.xfer(1'b1, PA, ra, 16'h0000, v);
    check(v, e);
  endtask

  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    logic [15:0] v;
    u_pec_host.xfer(1'b0, PA, ra, d, v);
  endtask

  task automatic irqc(input logic e);
    check({15'h0000, irq}, {15'h0000, e});
  endtask

  task automatic pulse(input int k);
    step(1);
    evt[k] = 1'b1;
    step(1);
    evt[k] = 1'b0;
    step(1);
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic t_reset;
    irqc(1'b1);
    rdc(REG_EVT_IRQ, 16'h0000);
    rdc(REG_CABLE, 16'h0000);
    rdc(REG_CTRL_ONE, 16'h0000);
    rdc(REG_CTRL_TWO, 16'h0000);
  endtask

  task automatic t_regs;
    wr(REG_EVT_IRQ, 16'hFFFF);
    rdc(REG_EVT_IRQ, 16'hFF00);
    wr(REG_CTRL_ONE, 16'hFFFF);
    rdc(REG_CTRL_ONE, 16'h0000);
    step(1);
    cap = 1'b1;
    rdc(REG_CTRL_ONE, 16'h0200);
    rdc(5'h00, 16'h0000);
  endtask

  task automatic t_events;
    for (int k = 0; k < 8; k++)
    begin
      wr(REG_EVT_IRQ, 16'h0100 << k);
      pulse(k);
      irqc(1'b0);
      rdc(REG_EVT_IRQ, 16'h0101 << k);
      irqc(1'b1);
      rdc(REG_EVT_IRQ, 16'h0100 << k);
    end
    wr(REG_CTRL_TWO, 16'h0200);
    step(3);
    irqc(1'b0);
    pulse(0);
    irqc(1'b0);
    pulse(7);
    irqc(1'b1);
    rdc(REG_EVT_IRQ, 16'h8081);
    irqc(1'b0);
  endtask

  task automatic t_cable;
    logic [15:0] v;
    logic [8:0]  c;
    logic [15:0] p;
    // Results of the previous test stay readable while busy
    p = 16'h8E00;
    for (int k = 0; k < 4; k++)
    begin
      c = 9'h1A5 ^ 9'(k);
      wr(REG_CABLE, 16'h8E00);
      step(3);
      check({15'h0000, busy}, 16'h0001);
      check(16'(starts), 16'(k + 1));
      wr(REG_CABLE, 16'h8E00);
      check(16'(starts), 16'(k + 1));
      rdc(REG_CABLE, p);
      res = 2'(k);
      short = k[0];
      cnt = c;
      done = 1'b1;
      step(1);
      done = 1'b0;
      res = ~res;
      short = ~short;
      cnt = ~cnt;
      v = 16'h8000;
      // Results are used only once the start bit reads clear
      for (int n = 0; n < 4 && v[15]; n++)
        u_pec_host.xfer(1'b1, PA, REG_CABLE, 16'h0000, v);
      check(v, {1'b0, 2'(k), k[0], 3'h7, c});
      p = {1'b1, 2'(k), k[0], 3'h7, c};
    end
  endtask

  initial
  begin
    #5_000_000;
    bad_count++;
    summarize;
  end

  initial
  begin
    repeat (16) @(posedge clk_in);
    #10;
    nrst_in = 1'b1;
    step(2);
    t_reset;
    t_regs;
    t_events;
    t_cable;
    summarize;
  end
endmodule

`default_nettype wire
